// >>> rtl/sori_top.sv
// Safety output with minimum OFF time and restart interlock, AXI4-Lite registers

// Notes on behaviour
// - An interrupted field forces the output OFF for at least 80 ms, even for a brief interruption.
// - The output has its own restart interlock that a control bit enables or disables.
// - The reset request arrives from the controller as a network signal through a register write.
// - With the interlock enabled the output stays OFF after the field clears.
// - With the interlock enabled the output returns ON only on a reset while the field is clear.
// - A reset while an object is in the field is ignored and the output stays OFF.
// - An accepted reset brings the block from stopped back to monitoring.
// - An accepted reset also clears a pending start-up interlock.
// - A reset is accepted only while all safety functions report healthy, else it is rejected.
module sori_top #(
    parameter int MIN_OFF_CYCLES = sori_pkg::SORI_MIN_OFF_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic field_busy,
    input wire logic functions_ok,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic safety_out
);
    typedef enum logic [2:0] {
        SORI_ST_STARTUP = 3'b001,
        SORI_ST_MONITOR = 3'b010,
        SORI_ST_STOPPED = 3'b100
    } sori_state_t;

    sori_state_t state;
    logic busy_meta, busy_sync, ok_meta, ok_sync;
    logic [1:0] ctrl;
    logic req_level, req_prev, rejected;
    logic [sori_pkg::SORI_CNT_W-1:0] off_cnt;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic req_edge, accept, pulse_active, next_on;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Reset to busy and not healthy, so the output cannot come ON before the pins are seen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_meta <= 1'b1;
            busy_sync <= 1'b1;
            ok_meta <= 1'b0;
            ok_sync <= 1'b0;
        end else begin
            busy_meta <= field_busy;
            busy_sync <= busy_meta;
            ok_meta <= functions_ok;
            ok_sync <= ok_meta;
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    // Address and data are caught separately so either may come first
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
        end
    end

    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = wr_go && aw_addr == sori_pkg::SORI_ADDR_CTRL;
    wire wr_reset = wr_go && aw_addr == sori_pkg::SORI_ADDR_RESET;
    wire wr_known = wr_go && (aw_addr == sori_pkg::SORI_ADDR_CTRL
        || aw_addr == sori_pkg::SORI_ADDR_RESET || aw_addr == sori_pkg::SORI_ADDR_STATUS);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sori_pkg::SORI_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? sori_pkg::SORI_RESP_OKAY : sori_pkg::SORI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and network reset request
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= sori_pkg::SORI_CTRL_RESET_VAL;
        end else if (wr_ctrl && w_strb[0]) begin
            ctrl <= w_data[1:0];
        end
    end

    // Request level is written by the controller over the network
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_level <= 1'b0;
            req_prev <= 1'b0;
        end else begin
            if (wr_reset && w_strb[0]) begin
                req_level <= w_data[sori_pkg::SORI_RESET_REQ];
            end
            req_prev <= req_level;
        end
    end

    // A held request does not release a later stop
    assign req_edge = req_level && !req_prev;
    // Field must be clear and all functions healthy
    assign accept = req_edge && !busy_sync && ok_sync;

    // ------------------------------------------------------------------
    // Output state machine
    // ------------------------------------------------------------------
    assign pulse_active = off_cnt != '0;

    // Reloaded on every busy cycle, so a long interruption still gets the full OFF time after it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt <= '0;
        end else if (busy_sync) begin
            off_cnt <= sori_pkg::SORI_CNT_W'(MIN_OFF_CYCLES - 1);
        end else if (pulse_active) begin
            off_cnt <= off_cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SORI_ST_STARTUP;
        end else begin
            case (state)
                SORI_ST_STARTUP: begin
                    if (!ctrl[sori_pkg::SORI_CTRL_STARTUP_EN] || accept) begin
                        state <= SORI_ST_MONITOR;
                    end
                end
                SORI_ST_MONITOR: begin
                    if (busy_sync && ctrl[sori_pkg::SORI_CTRL_INTERLOCK_EN]) begin
                        state <= SORI_ST_STOPPED;
                    end
                end
                SORI_ST_STOPPED: begin
                    if (accept || !ctrl[sori_pkg::SORI_CTRL_INTERLOCK_EN]) begin
                        state <= SORI_ST_MONITOR;
                    end
                end
                default: state <= SORI_ST_STARTUP;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rejected <= 1'b0;
        end else if (req_edge) begin
            rejected <= !accept;
        end
    end

    assign next_on = state == SORI_ST_MONITOR && !busy_sync && !pulse_active && ok_sync;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            safety_out <= 1'b0;
        end else begin
            safety_out <= next_on;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sori_pkg::SORI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= sori_pkg::SORI_RESP_OKAY;
            case (s_axi_araddr)
                sori_pkg::SORI_ADDR_CTRL: s_axi_rdata <= {30'h0, ctrl};
                sori_pkg::SORI_ADDR_STATUS: s_axi_rdata <= {26'h0, rejected, pulse_active,
                    ok_sync, state != SORI_ST_MONITOR, busy_sync, safety_out};
                sori_pkg::SORI_ADDR_RESET: s_axi_rdata <= {31'h0, req_level};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= sori_pkg::SORI_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_busy_drops_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy_sync |=> !safety_out)
        else $error("output on while field busy");
    a_pulse_holds_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(busy_sync) |=> !safety_out [*8])
        else $error("off pulse too short");
    a_stays_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == SORI_ST_STOPPED && !accept && ctrl[0] |=> state == SORI_ST_STOPPED)
        else $error("interlock released without reset");
    a_on_needs_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(safety_out) |-> $past(state) == SORI_ST_MONITOR)
        else $error("output on from stopped state");
    a_busy_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_edge && busy_sync |=> rejected)
        else $error("reset with object not rejected");
    a_reset_monitor: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && state == SORI_ST_STOPPED |=> state == SORI_ST_MONITOR)
        else $error("accepted reset did not resume");
    a_startup_cleared: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && state == SORI_ST_STARTUP |=> state == SORI_ST_MONITOR)
        else $error("startup interlock not cleared");
    a_fault_rejects: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_edge && !ok_sync |=> rejected && !safety_out)
        else $error("reset accepted while faulty");
    a_edge_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_level && req_prev |-> !accept)
        else $error("held request accepted again");
    a_write_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_go |=> s_axi_bvalid)
        else $error("write not answered");
    a_fault_drops_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ok_sync |=> !safety_out)
        else $error("output on while functions faulty");
    a_object_keeps_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_edge && busy_sync && state == SORI_ST_STOPPED
        && ctrl[sori_pkg::SORI_CTRL_INTERLOCK_EN] |=> state == SORI_ST_STOPPED && !safety_out)
        else $error("reset with object released the output");

    c_stop_event: cover property (@(posedge core_clk) disable iff (!rst_n)
        state == SORI_ST_MONITOR ##1 state == SORI_ST_STOPPED);
    c_reset_ok: cover property (@(posedge core_clk) disable iff (!rst_n)
        accept && state == SORI_ST_STOPPED);
    c_reset_rejected: cover property (@(posedge core_clk) disable iff (!rst_n)
        req_edge && busy_sync);
    c_output_on: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(safety_out));
    c_startup_skip: cover property (@(posedge core_clk) disable iff (!rst_n)
        state == SORI_ST_STARTUP && !ctrl[sori_pkg::SORI_CTRL_STARTUP_EN]);
endmodule

// >>> shared/sori_pkg.sv
// Package for the safety output restart interlock block: register map, fields, timing
package sori_pkg;
    // Register byte addresses
    localparam logic [7:0] SORI_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SORI_ADDR_STATUS = 8'h04;
    localparam logic [7:0] SORI_ADDR_RESET = 8'h08;
    // Control register fields
    localparam int SORI_CTRL_INTERLOCK_EN = 0;
    localparam int SORI_CTRL_STARTUP_EN = 1;
    localparam logic [1:0] SORI_CTRL_RESET_VAL = 2'h3;
    // Status register fields
    localparam int SORI_STAT_OUTPUT_ON = 0;
    localparam int SORI_STAT_FIELD_BUSY = 1;
    localparam int SORI_STAT_LOCKED = 2;
    localparam int SORI_STAT_HEALTHY = 3;
    localparam int SORI_STAT_PULSE = 4;
    localparam int SORI_STAT_REJECTED = 5;
    // Reset request register field
    localparam int SORI_RESET_REQ = 0;
    // AXI responses
    localparam logic [1:0] SORI_RESP_OKAY = 2'h0;
    localparam logic [1:0] SORI_RESP_SLVERR = 2'h2;
    // Minimum OFF time
    localparam int SORI_CLK_MHZ = 125;
    localparam int SORI_MIN_OFF_MS = 80;
    localparam int SORI_MIN_OFF_CYCLES = SORI_MIN_OFF_MS * 1000 * SORI_CLK_MHZ;
    localparam int SORI_CNT_W = 24;
endpackage

// >>> verif/sori_ctrl_model.sv
// Controller model: AXI4-Lite master that reads status and sends reset requests
module sori_ctrl_model (
    input wire logic core_clk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
    end
    // Reset requests leave the controller only as register writes
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// >>> verif/tb_safety_output_restart_interlock.sv
// Testbench for the safety output restart interlock block
module tb_safety_output_restart_interlock;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_OFF = 20;
    logic core_clk, rst_n, field_busy, functions_ok, safety_out;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int num_errors = 0;
    int n_checks = 0;
    sori_top #(.MIN_OFF_CYCLES(MIN_OFF)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .field_busy(field_busy), .functions_ok(functions_ok),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .safety_out(safety_out));
    sori_ctrl_model ctl (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr_req(input logic b);
        ctl.wr(sori_pkg::SORI_ADDR_RESET, {31'h0, b}, r);
        check("reset write resp", r, sori_pkg::SORI_RESP_OKAY);
    endtask
    // Request is raised then dropped so the next one is a fresh edge
    task automatic req_reset();
        wr_req(1'b1);
        wr_req(1'b0);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic rd_stat();
        ctl.rd(sori_pkg::SORI_ADDR_STATUS, d, r);
        check("status read resp", r, sori_pkg::SORI_RESP_OKAY);
    endtask
    task automatic pulse_field();
        @(posedge core_clk);
        field_busy <= 1'b1;
        repeat (2) @(posedge core_clk);
        field_busy <= 1'b0;
    endtask
    initial begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        field_busy = 1'b0;
        functions_ok = 1'b1;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        ctl.rd(sori_pkg::SORI_ADDR_CTRL, d, r);
        check("ctrl reset", d[1:0], sori_pkg::SORI_CTRL_RESET_VAL);
        ctl.rd(8'h0C, d, r);
        check("unmapped read", r, sori_pkg::SORI_RESP_SLVERR);
        ctl.wr(8'h0C, 32'h0000_0001, r);
        check("unmapped write", r, sori_pkg::SORI_RESP_SLVERR);
        repeat (MIN_OFF) @(posedge core_clk);
        check("out at startup", {1'b0, safety_out}, 2'h0);
        req_reset();
        check("out after startup reset", {1'b0, safety_out}, 2'h1);
        $display("test startup done");
        pulse_field();
        repeat (3) @(posedge core_clk);
        check("out on interruption", {1'b0, safety_out}, 2'h0);
        repeat (MIN_OFF + 10) @(posedge core_clk);
        check("out after field clears", {1'b0, safety_out}, 2'h0);
        rd_stat();
        check("locked", {1'b0, d[sori_pkg::SORI_STAT_LOCKED]}, 2'h1);
        $display("test interlock done");
        field_busy <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr_req(1'b1);
        repeat (4) @(posedge core_clk);
        check("out with object", {1'b0, safety_out}, 2'h0);
        rd_stat();
        check("rejected busy", {1'b0, d[sori_pkg::SORI_STAT_REJECTED]}, 2'h1);
        check("status busy", {1'b0, d[sori_pkg::SORI_STAT_FIELD_BUSY]}, 2'h1);
        check("status off timer", {1'b0, d[sori_pkg::SORI_STAT_PULSE]}, 2'h1);
        field_busy <= 1'b0;
        repeat (MIN_OFF + 10) @(posedge core_clk);
        check("held request", {1'b0, safety_out}, 2'h0);
        wr_req(1'b0);
        req_reset();
        check("out after reset", {1'b0, safety_out}, 2'h1);
        rd_stat();
        check("unlocked", {1'b0, d[sori_pkg::SORI_STAT_LOCKED]}, 2'h0);
        check("status on", {1'b0, d[sori_pkg::SORI_STAT_OUTPUT_ON]}, 2'h1);
        $display("test object reset done");
        functions_ok <= 1'b0;
        repeat (4) @(posedge core_clk);
        req_reset();
        rd_stat();
        check("rejected unhealthy", {1'b0, d[sori_pkg::SORI_STAT_REJECTED]}, 2'h1);
        check("status healthy", {1'b0, d[sori_pkg::SORI_STAT_HEALTHY]}, 2'h0);
        check("out unhealthy", {1'b0, safety_out}, 2'h0);
        functions_ok <= 1'b1;
        repeat (4) @(posedge core_clk);
        req_reset();
        check("out healthy again", {1'b0, safety_out}, 2'h1);
        $display("test health done");
        ctl.wr(sori_pkg::SORI_ADDR_CTRL, 32'h0000_0000, r);
        pulse_field();
        repeat (MIN_OFF - 3) @(posedge core_clk);
        check("min off time", {1'b0, safety_out}, 2'h0);
        repeat (12) @(posedge core_clk);
        check("auto return", {1'b0, safety_out}, 2'h1);
        $display("test no interlock done");
        // Second reset: start-up interlock switched off by configuration, restart one kept
        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        ctl.rd(sori_pkg::SORI_ADDR_CTRL, d, r);
        check("ctrl after reset", d[1:0], sori_pkg::SORI_CTRL_RESET_VAL);
        ctl.wr(sori_pkg::SORI_ADDR_CTRL, 32'h0000_0001, r);
        check("ctrl write resp", r, sori_pkg::SORI_RESP_OKAY);
        repeat (MIN_OFF + 10) @(posedge core_clk);
        check("out without startup lock", {1'b0, safety_out}, 2'h1);
        pulse_field();
        repeat (MIN_OFF + 10) @(posedge core_clk);
        check("out locked again", {1'b0, safety_out}, 2'h0);
        $display("test startup off done");
        tally_and_finish();
    end
endmodule
